/* core/cwsl_pkg.sv */
package cwsl_pkg;
  // operating modes of the device
  typedef enum logic [5:0] {
    CWSL_RESET   = 6'b000001,
    CWSL_NREQ    = 6'b000010,
    CWSL_NORMAL  = 6'b000100,
    CWSL_STANDBY = 6'b001000,
    CWSL_STOP    = 6'b010000,
    CWSL_SLEEP   = 6'b100000
  } cwsl_mode_t;
  // wake detector filter states
  typedef enum logic [2:0] {
    CWSL_W_IDLE  = 3'b001,
    CWSL_W_PULSE = 3'b010,
    CWSL_W_GAP   = 3'b100
  } cwsl_wstate_t;
endpackage : cwsl_pkg

/* core/cwsl_regs.svh */
`ifndef CWSL_REGS_SVH
`define CWSL_REGS_SVH
// timing figures and derived cycle counts at 100 MHz
`define CWSL_CLK_MHZ          100
`define CWSL_PULSE_MIN_NS     500
`define CWSL_PULSE_MAX_US     500
`define CWSL_GAP_MAX_US       500
`define CWSL_INT_PULSE_US     10
`define CWSL_PULSE_MIN_CYC    ((`CWSL_PULSE_MIN_NS * `CWSL_CLK_MHZ) / 1000 + 1)
`define CWSL_PULSE_MAX_CYC    (`CWSL_PULSE_MAX_US * `CWSL_CLK_MHZ)
`define CWSL_GAP_MAX_CYC      (`CWSL_GAP_MAX_US * `CWSL_CLK_MHZ)
`define CWSL_INT_PULSE_CYC    (`CWSL_INT_PULSE_US * `CWSL_CLK_MHZ)
`define CWSL_WAKE_PULSES      3
`define CWSL_HS_PERIOD_CYC    100000
`define CWSL_HS_ON_CYC        35000
// io_status_reg field positions
`define CWSL_IOS_LEVEL_LSB    0
`define CWSL_IOS_AUX_LOW      4
`define CWSL_IOS_SW_HEAT      5
`define CWSL_IOS_BAT_LOW      6
`define CWSL_IOS_RST          8'h00
`endif

/* core/cwsl_sync.sv */
`timescale 1ns/100ps
module cwsl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  // change counts once second and third stage agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : q_reg[g];
    end
  endgenerate
  // three-stage capture
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end
  assign q_o = q_reg;
endmodule : cwsl_sync

/* core/cwsl_top.sv */
`timescale 1ns/100ps
`include "cwsl_regs.svh"
// How it works
// RL1 - bus pulse counts only if wider than 0.5 us and narrower than 500 us
// RL2 - a rejected pulse clears the pulse counter and gives no wake
// RL3 - accepted pulses increment counter; third one asserts wake
// RL4 - gap over 500 us between accepted pulses clears counter, no wake
// RL5 - entering CAN Normal mode ends wake cycle and clears CAN wake flag
// RL6 - a control input disables CAN bus wake detection
// RL7 - transmit low drives bus dominant, high drives recessive
// RL8 - receive output low when bus dominant, high when recessive
// RL9 - reset output low in reset mode, high otherwise
// RL10 - reset output forced low while main supply under threshold
// RL11 - enabled event pulls interrupt low until software clears source
// RL12 - in Stop mode a wake gives a 10 us interrupt pulse instead
// RL13 - watchdog fault output low when watchdog not serviced
// RL14 - supply-loss flag set below 3.0 V in every mode
// RL15 - battery-low reported and interrupting only in Normal and Standby
// RL16 - heat warning sets flag; shutdown level turns main supply off
// RL17 - aux-low status bit is 1 while aux supply is low
// RL18 - switch overheat shuts switch, sets status and combined event bit
// RL19 - battery switch from control bit; periodic in Sleep and Stop
// RL20 - timing base is fast oscillator awake, low-power one asleep
// RL21 - serial data sampled on falling and shifted on rising clock edges
// RL22 - level inputs readable and wake sources in Sleep or Stop
// RL23 - disabling bus wake clears counter and timeout
module cwsl_top
  import cwsl_pkg::*;
#(
  parameter int PULSE_MAX = `CWSL_PULSE_MAX_CYC,
  parameter int GAP_MAX   = `CWSL_GAP_MAX_CYC,
  parameter int HS_PERIOD = `CWSL_HS_PERIOD_CYC,
  parameter int HS_ON     = `CWSL_HS_ON_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [5:0] mode_i,
  input  wire logic       can_normal_i,
  input  wire logic       can_wake_en_i,
  input  wire logic       tx_data_i,
  input  wire logic       bus_dom_i,
  input  wire logic       main_supply_low_i,
  input  wire logic       wd_fail_i,
  input  wire logic       bat_loss_i,
  input  wire logic       bat_low_i,
  input  wire logic       main_heat_warn_i,
  input  wire logic       main_heat_shut_i,
  input  wire logic       aux_supply_low_i,
  input  wire logic       switch_heat_i,
  input  wire logic [3:0] level_wake_inputs_i,
  input  wire logic       switch_on_i,
  input  wire logic [4:0] event_enable_i,
  input  wire logic [4:0] event_clear_i,
  input  wire logic       supply_loss_clear_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_mosi_i,
  output logic            bus_drive_dom_o,
  output logic            rx_data_o,
  output logic            reset_out_n_o,
  output logic            int_out_n_o,
  output logic            watchdog_fault_out_n_o,
  output logic            supply_loss_flag_o,
  output logic            main_supply_heat_flag_o,
  output logic            main_supply_off_o,
  output logic [7:0]      io_status_o,
  output logic [4:0]      event_flag_o,
  output logic            can_wake_flag_o,
  output logic            battery_switch_out_o,
  output logic            wake_request_o,
  output logic            slow_osc_sel_o,
  output logic            spi_miso_o,
  output logic [7:0]      spi_rx_o
);
  // synchronised outside levels; tx and chip select enter inverted so idle reads 0
  logic [16:0] raw_in;
  logic [16:0] syn;
  assign raw_in = {!spi_cs_n_i, spi_sclk_i, spi_mosi_i,
                   !tx_data_i, bus_dom_i, main_supply_low_i, wd_fail_i, bat_loss_i,
                   bat_low_i, main_heat_warn_i, main_heat_shut_i, aux_supply_low_i,
                   switch_heat_i, level_wake_inputs_i};
  cwsl_sync #(.W(17)) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (raw_in),
    .q_o       (syn)
  );
  wire       sel_s       = syn[16];
  wire       sck_s       = syn[15];
  wire       mosi_s      = syn[14];
  wire       tx_dom_s    = syn[13];
  wire       dom_s       = syn[12];
  wire       vmain_low_s = syn[11];
  wire       wdf_s       = syn[10];
  wire       loss_s      = syn[9];
  wire       blow_s      = syn[8];
  wire       hwarn_s     = syn[7];
  wire       hshut_s     = syn[6];
  wire       aux_low_s   = syn[5];
  wire       sw_heat_s   = syn[4];
  wire [3:0] lvl_s       = syn[3:0];

  // mode decode
  wire m_reset  = (mode_i == 6'(CWSL_RESET));
  wire m_normal = (mode_i == 6'(CWSL_NORMAL));
  wire m_stby   = (mode_i == 6'(CWSL_STANDBY));
  wire m_stop   = (mode_i == 6'(CWSL_STOP));
  wire m_sleep  = (mode_i == 6'(CWSL_SLEEP));
  wire m_lowpwr = m_stop || m_sleep;
  wire m_awake  = m_normal || m_stby;

  // bus wake detector
  cwsl_wake_if wk ();
  assign wk.bus_dom = dom_s;
  assign wk.enable  = can_wake_en_i && !can_normal_i; // RL6 RL5
  cwsl_wake_det #(
    .PULSE_MAX (PULSE_MAX),
    .GAP_MAX   (GAP_MAX)
  ) u_wake (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .wk        (wk)
  );

  // level wake edges in low power
  logic [3:0] lvl_prev_reg;
  wire        lvl_wake = m_lowpwr && (lvl_s != lvl_prev_reg); // RL22
  wire        can_wake_ev = wk.wake && !can_wake_flag_o;
  wire        any_wake = can_wake_ev || lvl_wake;

  // event flags: 0 bat low, 1 switch heat or aux low, 2 main heat, 3 can wake, 4 level wake
  wire [4:0] ev_set = {lvl_wake, can_wake_ev, hwarn_s,
                       sw_heat_s || aux_low_s, blow_s && m_awake}; // RL15 RL18 RL16
  logic [4:0] ev_reg;
  logic [4:0] ev_next;
  assign ev_next = ev_set | (ev_reg & ~event_clear_i); // set wins
  wire int_level = |(ev_reg & event_enable_i); // RL11

  // stop-mode interrupt pulse timer
  logic [15:0] ipulse_reg;
  logic [15:0] ipulse_next;
  assign ipulse_next = (m_stop && any_wake) ? 16'(`CWSL_INT_PULSE_CYC) :
                       (ipulse_reg != 16'h0000) ? ipulse_reg - 16'h0001 : 16'h0000; // RL12
  wire int_drive = m_stop ? (ipulse_next != 16'h0000) : int_level; // RL12 RL11

  // periodic battery switch timer
  logic [31:0] hs_cnt_reg;
  logic [31:0] hs_cnt_next;
  assign hs_cnt_next = (!m_lowpwr || hs_cnt_reg >= 32'(HS_PERIOD - 1)) ? 32'h0 :
                       hs_cnt_reg + 32'h1;
  wire hs_on = m_lowpwr ? (switch_on_i && hs_cnt_reg < 32'(HS_ON)) :
               (switch_on_i && (m_awake || mode_i == 6'(CWSL_NREQ))); // RL19
  logic sw_shut_reg;
  wire  sw_shut_next = sw_heat_s || (sw_shut_reg && switch_on_i); // RL18

  // can wake flag held until CAN Normal
  wire cwf_next = wk.wake || (can_wake_flag_o && !can_normal_i); // RL5
  wire loss_next = loss_s || (supply_loss_flag_o && !supply_loss_clear_i); // RL14

  // status word
  wire [7:0] ios_next = {1'b0, m_awake && blow_s, sw_heat_s, aux_low_s, lvl_s}; // RL17 RL22

  // serial port: mosi taken on falling sclk, miso moved on rising sclk
  logic       sel_prev_reg;
  logic       sck_prev_reg;
  logic [7:0] spi_sh_reg;
  logic [7:0] spi_in_reg;
  logic [2:0] spi_cnt_reg;
  wire        sel_rise     = sel_s && !sel_prev_reg; // status snapshot at selection
  wire        sck_rise     = sel_s && sck_s && !sck_prev_reg; // RL21
  wire        sck_fall     = sel_s && !sck_s && sck_prev_reg; // RL21
  wire [7:0]  spi_sh_next  = sel_rise ? io_status_o :
                             sck_rise ? {spi_sh_reg[6:0], 1'b0} : spi_sh_reg;
  wire [7:0]  spi_in_next  = sck_fall ? {spi_in_reg[6:0], mosi_s} : spi_in_reg; // RL21
  wire [2:0]  spi_cnt_next = sel_rise ? 3'h0 : sck_fall ? spi_cnt_reg + 3'h1 : spi_cnt_reg;
  wire        spi_done     = sck_fall && (spi_cnt_reg == 3'h7); // eighth bit in

  // internal state
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_prev_reg <= 4'h0;
      ev_reg       <= 5'h00;
      ipulse_reg   <= 16'h0000;
      hs_cnt_reg   <= 32'h0;
      sw_shut_reg  <= 1'b0;
      sel_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      spi_sh_reg   <= 8'h00;
      spi_in_reg   <= 8'h00;
      spi_cnt_reg  <= 3'h0;
    end else begin
      lvl_prev_reg <= lvl_s;
      ev_reg       <= ev_next;
      ipulse_reg   <= ipulse_next;
      hs_cnt_reg   <= hs_cnt_next;
      sw_shut_reg  <= sw_shut_next;
      sel_prev_reg <= sel_s;
      sck_prev_reg <= sck_s;
      spi_sh_reg   <= spi_sh_next;
      spi_in_reg   <= spi_in_next;
      spi_cnt_reg  <= spi_cnt_next;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_drive_dom_o         <= 1'b0;
      rx_data_o               <= 1'b1;
      reset_out_n_o           <= 1'b0;
      int_out_n_o             <= 1'b1;
      watchdog_fault_out_n_o  <= 1'b1;
      supply_loss_flag_o      <= 1'b0;
      main_supply_heat_flag_o <= 1'b0;
      main_supply_off_o       <= 1'b0;
      io_status_o             <= `CWSL_IOS_RST;
      event_flag_o            <= 5'h00;
      can_wake_flag_o         <= 1'b0;
      battery_switch_out_o    <= 1'b0;
      wake_request_o          <= 1'b0;
      slow_osc_sel_o          <= 1'b0;
      spi_miso_o              <= 1'b0;
      spi_rx_o                <= 8'h00;
    end else begin
      bus_drive_dom_o         <= tx_dom_s; // RL7
      rx_data_o               <= !dom_s; // RL8
      reset_out_n_o           <= !(m_reset || vmain_low_s); // RL9 RL10
      int_out_n_o             <= !int_drive; // RL11
      watchdog_fault_out_n_o  <= !wdf_s; // RL13
      supply_loss_flag_o      <= loss_next; // RL14
      main_supply_heat_flag_o <= hwarn_s; // RL16
      main_supply_off_o       <= hshut_s; // RL16
      io_status_o             <= ios_next;
      event_flag_o            <= ev_next;
      can_wake_flag_o         <= cwf_next;
      battery_switch_out_o    <= hs_on && !sw_shut_next; // RL19 RL18
      wake_request_o          <= m_lowpwr && any_wake; // RL22
      slow_osc_sel_o          <= m_lowpwr; // RL20
      spi_miso_o              <= sck_rise ? spi_sh_reg[7] : spi_miso_o; // RL21
      spi_rx_o                <= spi_done ? spi_in_next : spi_rx_o; // RL21
    end
  end
endmodule : cwsl_top

/* core/cwsl_wake_det.sv */
`timescale 1ns/100ps
`include "cwsl_regs.svh"
module cwsl_wake_det
  import cwsl_pkg::*;
#(
  parameter int PULSE_MIN = `CWSL_PULSE_MIN_CYC,
  parameter int PULSE_MAX = `CWSL_PULSE_MAX_CYC,
  parameter int GAP_MAX   = `CWSL_GAP_MAX_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  cwsl_wake_if.det  wk
);
  cwsl_wstate_t state_reg;
  cwsl_wstate_t state_next;
  logic [16:0]  cnt_reg;
  logic [16:0]  cnt_next;
  logic [1:0]   pulses_reg;
  logic [1:0]   pulses_next;
  logic         wake_reg;
  logic         wake_next;
  // width filter and spacing timeout decode
  wire pulse_end  = (state_reg == CWSL_W_PULSE) && !wk.bus_dom;
  // cnt_reg trails the dominant width by one cycle when the pulse ends
  wire width_ok   = (cnt_reg >= 17'(PULSE_MIN - 1)) && (cnt_reg < 17'(PULSE_MAX - 1)); // RL1
  wire width_over = (state_reg == CWSL_W_PULSE) && (cnt_reg >= 17'(PULSE_MAX - 1));
  wire gap_over   = (state_reg == CWSL_W_GAP) && (cnt_reg >= 17'(GAP_MAX));
  wire accept     = pulse_end && width_ok;
  wire reject     = pulse_end && !width_ok;
  // next state
  always_comb begin
    state_next  = state_reg;
    cnt_next    = (cnt_reg == 17'h1ffff) ? cnt_reg : cnt_reg + 17'h00001;
    pulses_next = pulses_reg;
    wake_next   = wake_reg;
    if (!wk.enable) begin
      state_next  = CWSL_W_IDLE; // RL23
      cnt_next    = 17'h00000;
      pulses_next = 2'h0;
      wake_next   = 1'b0; // RL6
    end else begin
      case (state_reg)
        CWSL_W_IDLE: begin
          cnt_next = 17'h00000;
          if (wk.bus_dom) state_next = CWSL_W_PULSE;
        end
        CWSL_W_PULSE: begin
          if (reject) begin
            state_next  = CWSL_W_IDLE;
            pulses_next = 2'h0; // RL2
          end else if (accept) begin
            cnt_next = 17'h00000;
            if (pulses_reg == 2'(`CWSL_WAKE_PULSES - 1)) begin
              wake_next   = 1'b1; // RL3
              pulses_next = 2'h0;
              state_next  = CWSL_W_IDLE;
            end else begin
              pulses_next = pulses_reg + 2'h1; // RL3
              state_next  = CWSL_W_GAP;
            end
          end else if (width_over) begin
            // stay here until recessive so the tail of a long pulse is not counted
            pulses_next = 2'h0; // RL2
          end
        end
        CWSL_W_GAP: begin
          if (gap_over) begin
            state_next  = CWSL_W_IDLE;
            pulses_next = 2'h0; // RL4
          end else if (wk.bus_dom) begin
            cnt_next   = 17'h00000;
            state_next = CWSL_W_PULSE;
          end
        end
        default: state_next = CWSL_W_IDLE;
      endcase
    end
  end
  // state registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg  <= CWSL_W_IDLE;
      cnt_reg    <= 17'h00000;
      pulses_reg <= 2'h0;
      wake_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pulses_reg <= pulses_next;
      wake_reg   <= wake_next;
    end
  end
  assign wk.wake = wake_reg;
endmodule : cwsl_wake_det

/* core/cwsl_wake_if.sv */
`timescale 1ns/100ps
interface cwsl_wake_if;
  logic bus_dom;
  logic enable;
  logic wake;
  modport det (input bus_dom, input enable, output wake);
  modport top (output bus_dom, output enable, input wake);
endinterface : cwsl_wake_if

/* verification/can_wakeup_and_status_logic_tb_top.sv */
`timescale 1ns/100ps
module can_wakeup_and_status_logic_tb_top;
  import cwsl_pkg::*;
  logic       sys_clk_i, nrst_i, can_normal_i, can_wake_en_i, tx_data_i, bus_dom_i;
  logic       main_supply_low_i, wd_fail_i, bat_loss_i, bat_low_i, main_heat_warn_i;
  logic       main_heat_shut_i, aux_supply_low_i, switch_heat_i, switch_on_i;
  logic       supply_loss_clear_i, bus_drive_dom_o, rx_data_o, reset_out_n_o, int_out_n_o;
  logic       watchdog_fault_out_n_o, supply_loss_flag_o, main_supply_heat_flag_o;
  logic       main_supply_off_o, can_wake_flag_o, battery_switch_out_o, wake_request_o;
  logic       slow_osc_sel_o;
  logic [5:0] mode_i;
  logic [3:0] level_wake_inputs_i;
  logic [4:0] event_enable_i, event_clear_i, event_flag_o;
  logic [7:0] io_status_o, ons, spi_rx_o, rd;
  logic       spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o;
  int         failures, checked;
  // counts shortened so the run stays short
  cwsl_top #(.PULSE_MAX(500), .GAP_MAX(500), .HS_PERIOD(100), .HS_ON(35)) DUT (
    .sys_clk_i, .nrst_i, .mode_i, .can_normal_i, .can_wake_en_i, .tx_data_i, .bus_dom_i,
    .main_supply_low_i, .wd_fail_i, .bat_loss_i, .bat_low_i, .main_heat_warn_i,
    .main_heat_shut_i, .aux_supply_low_i, .switch_heat_i, .level_wake_inputs_i,
    .switch_on_i, .event_enable_i, .event_clear_i, .supply_loss_clear_i, .bus_drive_dom_o,
    .rx_data_o, .reset_out_n_o, .int_out_n_o, .watchdog_fault_out_n_o, .supply_loss_flag_o,
    .main_supply_heat_flag_o, .main_supply_off_o, .io_status_o, .event_flag_o,
    .can_wake_flag_o, .battery_switch_out_o, .wake_request_o, .slow_osc_sel_o,
    .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_miso_o, .spi_rx_o);
  cwsl_can_node node (.sys_clk_i, .tx_data_o(tx_data_i), .bus_dom_o(bus_dom_i));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wt
  task automatic clr_events();
    event_clear_i <= 5'h1f;
    wt(1);
    event_clear_i <= 5'h00;
  endtask : clr_events
  // one byte, msb first; sclk idles low, eight cycles per half bit for the synchroniser
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    wt(1);
    spi_cs_n_i <= 1'b0;
    wt(8);
    for (int i = 7; i >= 0; i--) begin
      spi_sclk_i <= 1'b1;
      spi_mosi_i <= tx[i];
      wt(8);
      rx[i] = spi_miso_o;
      spi_sclk_i <= 1'b0;
      wt(8);
    end
    spi_cs_n_i <= 1'b1;
    wt(8);
  endtask : spi_xfer
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, well past the expected run
  initial begin
    #500000;
    failures++;
    finish_test();
  end
  initial begin
    {nrst_i, can_normal_i, can_wake_en_i, main_supply_low_i, wd_fail_i, bat_loss_i,
     bat_low_i, main_heat_warn_i, main_heat_shut_i, aux_supply_low_i, switch_heat_i,
     switch_on_i, supply_loss_clear_i, level_wake_inputs_i, event_enable_i,
     event_clear_i} = '0;
    mode_i = CWSL_RESET;
    {spi_sclk_i, spi_mosi_i} = 2'b00;
    spi_cs_n_i = 1'b1;
    failures = 0;
    checked = 0;
    wt(12);
    nrst_i <= 1'b1;
    can_wake_en_i <= 1'b1;
    wt(4);
    #1 chk(reset_out_n_o, 8'h00);
    wt(1);
    mode_i <= CWSL_NORMAL;
    wt(3);
    #1 chk(reset_out_n_o, 8'h01);
    node.drive(1'b1);
    wt(6);
    #1 chk({bus_drive_dom_o, rx_data_o}, 8'h02);
    node.drive(1'b0);
    wt(600);
    #1 chk({bus_drive_dom_o, rx_data_o}, 8'h01);
    $display("bus state test done");
    node.pulses(2, 100, 200);
    node.pulses(1, 60, 100);
    #1 chk({can_wake_flag_o, event_flag_o[3]}, 8'h03);
    can_normal_i <= 1'b1;
    wt(5);
    #1 chk(can_wake_flag_o, 8'h00);
    can_normal_i <= 1'b0;
    clr_events();
    $display("wake test done");
    node.pulses(2, 100, 100);
    node.pulses(1, 20, 100);
    node.pulses(1, 100, 600);
    node.pulses(2, 100, 100);
    node.pulses(1, 520, 100);
    node.pulses(1, 100, 600);
    #1 chk(can_wake_flag_o, 8'h00);
    node.pulses(2, 100, 100);
    wt(600);
    node.pulses(1, 100, 600);
    #1 chk(can_wake_flag_o, 8'h00);
    node.pulses(2, 100, 100);
    can_wake_en_i <= 1'b0;
    node.pulses(3, 100, 100);
    can_wake_en_i <= 1'b1;
    node.pulses(1, 100, 600);
    #1 chk(can_wake_flag_o, 8'h00);
    $display("wake reject test done");
    level_wake_inputs_i <= 4'ha;
    {aux_supply_low_i, main_supply_low_i, wd_fail_i, bat_loss_i} <= 4'hf;
    {bat_low_i, main_heat_warn_i, main_heat_shut_i} <= 3'h7;
    event_enable_i <= 5'h02;
    wt(8);
    #1 chk(io_status_o, 8'h5a);
    chk({reset_out_n_o, watchdog_fault_out_n_o, int_out_n_o}, 8'h00);
    chk({main_supply_off_o, main_supply_heat_flag_o, supply_loss_flag_o}, 8'h07);
    spi_xfer(8'h3c, rd);
    chk(rd, 8'h5a);
    chk(spi_rx_o, 8'h3c);
    {aux_supply_low_i, main_supply_low_i, wd_fail_i, bat_loss_i} <= 4'h0;
    {bat_low_i, main_heat_warn_i, main_heat_shut_i} <= 3'h0;
    wt(8);
    #1 chk({supply_loss_flag_o, int_out_n_o, reset_out_n_o}, 8'h05);
    supply_loss_clear_i <= 1'b1;
    clr_events();
    supply_loss_clear_i <= 1'b0;
    wt(3);
    #1 chk({supply_loss_flag_o, int_out_n_o}, 8'h01);
    $display("status test done");
    switch_on_i <= 1'b1;
    wt(4);
    #1 chk(battery_switch_out_o, 8'h01);
    mode_i <= CWSL_STANDBY;
    bat_low_i <= 1'b1;
    wt(8);
    #1 chk({battery_switch_out_o, io_status_o[6], slow_osc_sel_o}, 8'h06);
    bat_low_i <= 1'b0;
    mode_i <= CWSL_NREQ;
    wt(8);
    #1 chk({battery_switch_out_o, io_status_o[6], slow_osc_sel_o}, 8'h04);
    mode_i <= CWSL_NORMAL;
    switch_heat_i <= 1'b1;
    wt(8);
    #1 chk({battery_switch_out_o, io_status_o[5], event_flag_o[1]}, 8'h03);
    {switch_heat_i, switch_on_i} <= 2'b00;
    wt(6);
    clr_events();
    mode_i <= CWSL_SLEEP;
    switch_on_i <= 1'b1;
    bat_low_i <= 1'b1;
    wt(8);
    #1 chk({slow_osc_sel_o, io_status_o[6]}, 8'h02);
    ons = 8'h00;
    repeat (100) begin
      wt(1);
      #1 ons = ons + battery_switch_out_o;
    end
    chk(ons, 8'h23);
    {switch_on_i, bat_low_i} <= 2'b00;
    mode_i <= CWSL_STOP;
    event_enable_i <= 5'h1f;
    clr_events();
    node.pulses(3, 100, 10);
    #1 chk(int_out_n_o, 8'h00);
    wt(900);
    #1 chk(int_out_n_o, 8'h00);
    wt(200);
    #1 chk(int_out_n_o, 8'h01);
    level_wake_inputs_i <= 4'h5;
    wt(5);
    #1 chk({wake_request_o, event_flag_o[4], int_out_n_o}, 8'h06);
    wt(1);
    #1 chk(wake_request_o, 8'h00);
    $display("switch and stop test done");
    finish_test();
  end
endmodule : can_wakeup_and_status_logic_tb_top

/* verification/cwsl_can_node.sv */
`timescale 1ns/100ps
module cwsl_can_node (
  input  wire logic sys_clk_i,
  output logic      tx_data_o,
  output logic      bus_dom_o
);
  // bus idles recessive
  initial begin
    tx_data_o = 1'b1;
    bus_dom_o = 1'b0;
  end
  // request one bus level; the bus follows the request
  task automatic drive(input logic dom);
    @(posedge sys_clk_i);
    tx_data_o <= !dom;
    bus_dom_o <= dom;
  endtask : drive
  // n dominant pulses of w cycles, each followed by g recessive cycles
  task automatic pulses(input int n, input int w, input int g);
    for (int i = 0; i < n; i++) begin
      drive(1'b1);
      repeat (w - 1) @(posedge sys_clk_i);
      drive(1'b0);
      repeat (g - 1) @(posedge sys_clk_i);
    end
  endtask : pulses
endmodule : cwsl_can_node

/* verification/cwsl_top_asserts.sv */
`timescale 1ns/100ps
module cwsl_top_asserts
  import cwsl_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic [5:0] mode_i,
  input wire logic       can_normal_i,
  input wire logic       can_wake_en_i,
  input wire logic       tx_data_i,
  input wire logic       bus_dom_i,
  input wire logic       main_supply_low_i,
  input wire logic       wd_fail_i,
  input wire logic       aux_supply_low_i,
  input wire logic       switch_heat_i,
  input wire logic       supply_loss_clear_i,
  input wire logic       bus_drive_dom_o,
  input wire logic       rx_data_o,
  input wire logic       reset_out_n_o,
  input wire logic       watchdog_fault_out_n_o,
  input wire logic       supply_loss_flag_o,
  input wire logic [7:0] io_status_o,
  input wire logic       can_wake_flag_o,
  input wire logic       battery_switch_out_o,
  input wire logic       slow_osc_sel_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // synced levels reach their outputs within six edges
  property p_tx; !tx_data_i [*6] |-> bus_drive_dom_o; endproperty
  a_tx: assert property (p_tx) else $error("bus drive not dominant");
  property p_rx; bus_dom_i [*6] |-> !rx_data_o; endproperty
  a_rx: assert property (p_rx) else $error("rx not low on dominant bus");
  property p_rst; (mode_i == CWSL_RESET) [*2] |-> !reset_out_n_o; endproperty
  a_rst: assert property (p_rst) else $error("reset output high in reset mode");
  property p_uv; main_supply_low_i [*6] |-> !reset_out_n_o; endproperty
  a_uv: assert property (p_uv) else $error("reset output high on low supply");
  property p_wd; wd_fail_i [*6] |-> !watchdog_fault_out_n_o; endproperty
  a_wd: assert property (p_wd) else $error("watchdog fault output high");
  property p_loss; supply_loss_flag_o && !supply_loss_clear_i |=> supply_loss_flag_o; endproperty
  a_loss: assert property (p_loss) else $error("supply loss flag dropped");
  property p_aux; aux_supply_low_i [*6] |-> io_status_o[4]; endproperty
  a_aux: assert property (p_aux) else $error("aux low bit not set");
  property p_heat; switch_heat_i [*6] |-> !battery_switch_out_o && io_status_o[5]; endproperty
  a_heat: assert property (p_heat) else $error("switch not shut on overheat");
  property p_wclr; can_normal_i [*3] |-> !can_wake_flag_o; endproperty
  a_wclr: assert property (p_wclr) else $error("wake flag kept in can normal");
  property p_dis; !can_wake_en_i [*8] |-> !$rose(can_wake_flag_o); endproperty
  a_dis: assert property (p_dis) else $error("wake while detection disabled");
  property p_lp; (mode_i == CWSL_SLEEP) [*3] |-> !io_status_o[6]; endproperty
  a_lp: assert property (p_lp) else $error("battery low reported asleep");
  property p_osc; (mode_i == CWSL_STOP || mode_i == CWSL_SLEEP) [*2] |-> slow_osc_sel_o;
  endproperty
  a_osc: assert property (p_osc) else $error("fast oscillator in low power");
endmodule : cwsl_top_asserts
bind cwsl_top cwsl_top_asserts u_chk (.sys_clk_i, .nrst_i, .mode_i, .can_normal_i,
  .can_wake_en_i, .tx_data_i, .bus_dom_i, .main_supply_low_i, .wd_fail_i, .aux_supply_low_i,
  .switch_heat_i, .supply_loss_clear_i, .bus_drive_dom_o, .rx_data_o, .reset_out_n_o,
  .watchdog_fault_out_n_o, .supply_loss_flag_o, .io_status_o, .can_wake_flag_o,
  .battery_switch_out_o, .slow_osc_sel_o);
